// ### design/ssl_consts.vh
// Constants of the status lamp and setting switch block: register offsets,
// field positions, reset values and timing counts.
// Assumes the includer runs on core_clk at 125 MHz.
//
// Behaviour
// - Run lamp dark when link down or reset
// - Run lamp steady green while communicating
// - Selector change during communication flashes error lamp
// - Error lamp steady on comm error, bad station
// - Sensor lamp dark: no amplifiers or initializing
// - Sensor lamp green when amplifier counts match
// - Sensor lamp red when amplifier counts differ
// - Codes 0-4: version 1 mode, five rates
// - Codes 5-9: version 2 mode, five rates
// - Selectors captured once at power-on only
// - Station number is tens times ten plus ones
// - Station 1-63 version 1, 1-62 version 2
// - Duplicate station number is error, operation stops
`ifndef SSL_CONSTS_VH
`define SSL_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SSL_ADDR_CONFIG       8'h00
`define SSL_ADDR_LAMPS        8'h04
`define SSL_ADDR_IRQ_STATUS   8'h08
`define SSL_ADDR_IRQ_MASK     8'h0C
`define SSL_ADDR_CONTROL      8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SSL_CFG_RATE_LSB      8
`define SSL_CFG_MONITOR_BIT   11
`define SSL_CFG_INRANGE_BIT   12
`define SSL_CFG_VALID_BIT     13
`define SSL_LMP_AMPREC_LSB    8
`define SSL_LMP_AMPNOW_LSB    16
`define SSL_CTL_CLRSEL_BIT    0

// Interrupt event bits
`define SSL_IRQ_LINK_DOWN     0
`define SSL_IRQ_COMM_ERR      1
`define SSL_IRQ_SEL_CHANGE    2
`define SSL_IRQ_AMP_MISMATCH  3
`define SSL_IRQ_DUP_STATION   4
`define SSL_IRQ_WIDTH         5

// ----------------------------------------------------------------------
// Reset values and selector decode
// ----------------------------------------------------------------------
`define SSL_IRQ_MASK_RESET    5'h00
`define SSL_MODE_SPLIT        4'h5
`define SSL_CODE_LAST         4'h9
`define SSL_DIGIT_LAST        4'h9
`define SSL_STATION_MIN       7'h01
`define SSL_STATION_MAX_V1    7'h3F
`define SSL_STATION_MAX_V2    7'h3E

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SSL_CLK_PERIOD_NS     8
`define SSL_SETTLE_NS         1000
`define SSL_SETTLE_CYCLES     ((`SSL_SETTLE_NS + `SSL_CLK_PERIOD_NS - 1) / `SSL_CLK_PERIOD_NS)
`define SSL_FLASH_HALF_MS     250
`define SSL_FLASH_HALF_CYCLES (`SSL_FLASH_HALF_MS * 1000000 / `SSL_CLK_PERIOD_NS)

`endif

// ### design/ssl_flasher.v
// Flash phase generator for the error lamp.
// Assumes run is a same-clock level; phase restarts lit when run rises.
`timescale 1ns/1ps

module ssl_flasher #(
    parameter [31:0] HALF_CYCLES = 32'h0000_0004
)(
    // Clock and reset
    input  wire        core_clk,
    input  wire        reset,
    // Control
    input  wire        run,
    // Phase out
    output wire        flashOn
);

    reg  [31:0] cntReg;
    reg  [31:0] cntNext;
    reg         phaseReg;
    reg         phaseNext;

    always @*
    begin
        cntNext   = cntReg;
        phaseNext = phaseReg;
        if (!run)
        begin
            cntNext   = 32'h0000_0000;
            phaseNext = 1'b1;
        end
        else if (cntReg >= HALF_CYCLES - 32'h0000_0001)
        begin
            cntNext   = 32'h0000_0000;
            phaseNext = ~phaseReg;
        end
        else
        begin
            cntNext = cntReg + 32'h0000_0001;
        end
    end

    always @(posedge core_clk)
    begin
        if (reset)
        begin
            cntReg   <= 32'h0000_0000;
            phaseReg <= 1'b1;
        end
        else
        begin
            cntReg   <= cntNext;
            phaseReg <= phaseNext;
        end
    end

    assign flashOn = phaseReg;

endmodule // ssl_flasher

// ### design/ssl_lamp_switch.v
// Status lamps and power-on setting switch capture of the sensor
// communications unit, with a small register port and one interrupt.
// Assumes switch pins are asynchronous; engine and scanner inputs are on
// core_clk; reset is held at power-on.
`timescale 1ns/1ps
`include "ssl_consts.vh"

module ssl_lamp_switch #(
    parameter [31:0] FLASH_HALF_CYCLES = `SSL_FLASH_HALF_CYCLES
)(
    // Clock and reset
    input  wire        core_clk,
    input  wire        reset,
    // Setting switch pins
    input  wire [3:0]  rateSwitchPin,
    input  wire [3:0]  stationTensPin,
    input  wire [3:0]  stationOnesPin,
    // Protocol engine
    input  wire        linkActive,
    input  wire        commError,
    input  wire        dupStation,
    // Sensor chain scanner
    input  wire [4:0]  ampCount,
    input  wire        ampCountValid,
    // Register port
    input  wire [7:0]  regAddr,
    input  wire [31:0] regWdata,
    input  wire        regWrite,
    input  wire        regRead,
    output reg  [31:0] regRdata,
    // Lamps
    output reg         runLampGreen,
    output reg         errLampRed,
    output reg         ssLampGreen,
    output reg         ssLampRed,
    // Captured settings
    output wire [2:0]  linkRate,
    output wire        monitorMode,
    output wire [6:0]  stationNumber,
    output wire        stationInRange,
    output wire        settingsValid,
    output wire        operationHalt,
    // Interrupt
    output wire        irq
);

    // ------------------------------------------------------------------
    // Switch synchronisers
    // ------------------------------------------------------------------
    wire [11:0] swPins;
    reg  [11:0] swSync1Reg;
    reg  [11:0] swSync2Reg;

    assign swPins = {rateSwitchPin, stationTensPin, stationOnesPin};

    genvar gi;
    generate
        for (gi = 0; gi < 12; gi = gi + 1)
        begin : gSync
            always @(posedge core_clk)
            begin
                if (reset)
                begin
                    swSync1Reg[gi] <= 1'b0;
                    swSync2Reg[gi] <= 1'b0;
                end
                else
                begin
                    swSync1Reg[gi] <= swPins[gi];
                    swSync2Reg[gi] <= swSync1Reg[gi];
                end
            end
        end
    endgenerate

    wire [3:0] liveRate  = swSync2Reg[11:8];
    wire [3:0] liveTens  = swSync2Reg[7:4];
    wire [3:0] liveOnes  = swSync2Reg[3:0];

    // ------------------------------------------------------------------
    // Power-on capture
    // ------------------------------------------------------------------
    // The settle wait lets the synchronisers fill before the one capture.
    reg  [7:0] settleCntReg;
    reg        capturedReg;
    reg  [3:0] rateCodeReg;
    reg  [3:0] tensReg;
    reg  [3:0] onesReg;

    always @(posedge core_clk)
    begin
        if (reset)
        begin
            settleCntReg <= 8'h00;
            capturedReg  <= 1'b0;
            rateCodeReg  <= 4'h0;
            tensReg      <= 4'h0;
            onesReg      <= 4'h0;
        end
        else if (!capturedReg)
        begin
            if (settleCntReg == `SSL_SETTLE_CYCLES - 1)
            begin
                capturedReg <= 1'b1;
                rateCodeReg <= liveRate;
                tensReg     <= liveTens;
                onesReg     <= liveOnes;
            end
            else
            begin
                settleCntReg <= settleCntReg + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Setting decode
    // ------------------------------------------------------------------
    wire       rateCodeOk = (rateCodeReg <= `SSL_CODE_LAST);
    wire       isMonitor  = (rateCodeReg >= `SSL_MODE_SPLIT);
    wire [3:0] rateIdx    = isMonitor ? (rateCodeReg - `SSL_MODE_SPLIT) : rateCodeReg;
    wire       digitsOk   = (tensReg <= `SSL_DIGIT_LAST) && (onesReg <= `SSL_DIGIT_LAST);
    // Tens times ten as two shifts, summed at station-number width
    wire [6:0] tensX10    = {tensReg, 3'b000} + {2'b00, tensReg, 1'b0};
    wire [6:0] stationSum = tensX10 + {3'b000, onesReg};
    wire [6:0] stationMax = isMonitor ? `SSL_STATION_MAX_V2 : `SSL_STATION_MAX_V1;
    wire       inRange    = rateCodeOk && digitsOk
                            && (stationSum >= `SSL_STATION_MIN)
                            && (stationSum <= stationMax);

    // The master must run at this rate; nothing here can detect a mismatch
    assign linkRate       = rateIdx[2:0];
    assign monitorMode    = isMonitor;
    assign stationNumber  = stationSum;
    assign stationInRange = inRange;
    assign settingsValid  = capturedReg;

    // ------------------------------------------------------------------
    // Fault latches
    // ------------------------------------------------------------------
    reg  haltReg;
    reg  selChangedReg;
    wire swDiffers = (liveRate != rateCodeReg) || (liveTens != tensReg)
                     || (liveOnes != onesReg);
    wire selSet    = capturedReg && linkActive && swDiffers;
    wire clrSel    = regWrite && (regAddr == `SSL_ADDR_CONTROL)
                     && regWdata[`SSL_CTL_CLRSEL_BIT];

    always @(posedge core_clk)
    begin
        if (reset)
        begin
            haltReg       <= 1'b0;
            selChangedReg <= 1'b0;
        end
        else
        begin
            // Duplicate station stops operation until the next power-up
            if (dupStation)
                haltReg <= 1'b1;
            // Set wins over a software clear in the same cycle
            if (selSet)
                selChangedReg <= 1'b1;
            else if (clrSel)
                selChangedReg <= 1'b0;
        end
    end

    assign operationHalt = haltReg;

    // ------------------------------------------------------------------
    // Lamp drive
    // ------------------------------------------------------------------
    wire flashOn;

    ssl_flasher #(
        .HALF_CYCLES (FLASH_HALF_CYCLES)
    ) uFlasher (
        .core_clk (core_clk),
        .reset    (reset),
        .run      (selChangedReg),
        .flashOn  (flashOn)
    );

    reg  [4:0] ampRecReg;
    reg        ampRecValidReg;
    wire       steadyErr   = commError || !inRange || haltReg;
    wire       ampMismatch = ampRecValidReg && (ampCount != ampRecReg);

    always @(posedge core_clk)
    begin
        if (reset)
        begin
            ampRecReg      <= 5'h00;
            ampRecValidReg <= 1'b0;
        end
        else if (capturedReg && ampCountValid && !ampRecValidReg)
        begin
            ampRecReg      <= ampCount;
            ampRecValidReg <= 1'b1;
        end
    end

    always @(posedge core_clk)
    begin
        if (reset)
        begin
            runLampGreen <= 1'b0;
            errLampRed   <= 1'b0;
            ssLampGreen  <= 1'b0;
            ssLampRed    <= 1'b0;
        end
        else
        begin
            runLampGreen <= capturedReg && linkActive && !haltReg;
            if (!capturedReg)
                errLampRed <= 1'b0;
            else if (steadyErr)
                errLampRed <= 1'b1;
            else if (selChangedReg)
                errLampRed <= flashOn;
            else
                errLampRed <= 1'b0;
            if (!ampRecValidReg || (ampCount == 5'h00))
            begin
                ssLampGreen <= 1'b0;
                ssLampRed   <= 1'b0;
            end
            else
            begin
                ssLampGreen <= !ampMismatch;
                ssLampRed   <= ampMismatch;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------------
    reg                       linkPrevReg;
    reg                       errPrevReg;
    reg                       mismPrevReg;
    reg                       haltPrevReg;
    reg                       selPrevReg;
    reg  [`SSL_IRQ_WIDTH-1:0] irqStatusReg;
    reg  [`SSL_IRQ_WIDTH-1:0] irqStatusNext;
    reg  [`SSL_IRQ_WIDTH-1:0] irqMaskReg;
    wire [`SSL_IRQ_WIDTH-1:0] events;

    assign events[`SSL_IRQ_LINK_DOWN]    = linkPrevReg && !linkActive;
    assign events[`SSL_IRQ_COMM_ERR]     = commError && !errPrevReg;
    assign events[`SSL_IRQ_SEL_CHANGE]   = selChangedReg && !selPrevReg;
    assign events[`SSL_IRQ_AMP_MISMATCH] = ampMismatch && !mismPrevReg;
    assign events[`SSL_IRQ_DUP_STATION]  = haltReg && !haltPrevReg;

    always @*
    begin
        irqStatusNext = irqStatusReg;
        if (regWrite && (regAddr == `SSL_ADDR_IRQ_STATUS))
            irqStatusNext = irqStatusNext & ~regWdata[`SSL_IRQ_WIDTH-1:0];
        // Set after clear so a same-cycle event is kept
        irqStatusNext = irqStatusNext | events;
    end

    always @(posedge core_clk)
    begin
        if (reset)
        begin
            linkPrevReg  <= 1'b0;
            errPrevReg   <= 1'b0;
            mismPrevReg  <= 1'b0;
            haltPrevReg  <= 1'b0;
            selPrevReg   <= 1'b0;
            irqStatusReg <= {`SSL_IRQ_WIDTH{1'b0}};
            irqMaskReg   <= `SSL_IRQ_MASK_RESET;
        end
        else
        begin
            linkPrevReg  <= linkActive;
            errPrevReg   <= commError;
            mismPrevReg  <= ampMismatch;
            haltPrevReg  <= haltReg;
            selPrevReg   <= selChangedReg;
            irqStatusReg <= irqStatusNext;
            if (regWrite && (regAddr == `SSL_ADDR_IRQ_MASK))
                irqMaskReg <= regWdata[`SSL_IRQ_WIDTH-1:0];
        end
    end

    assign irq = |(irqStatusReg & irqMaskReg);

    // ------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------
    reg [31:0] rdNext;

    always @*
    begin
        rdNext = 32'h0000_0000;
        case (regAddr)
            `SSL_ADDR_CONFIG:
            begin
                rdNext[6:0]                                  = stationSum;
                rdNext[`SSL_CFG_RATE_LSB+2:`SSL_CFG_RATE_LSB] = rateIdx[2:0];
                rdNext[`SSL_CFG_MONITOR_BIT]                 = isMonitor;
                rdNext[`SSL_CFG_INRANGE_BIT]                 = inRange;
                rdNext[`SSL_CFG_VALID_BIT]                   = capturedReg;
            end
            `SSL_ADDR_LAMPS:
            begin
                rdNext[0] = runLampGreen;
                rdNext[1] = errLampRed;
                rdNext[2] = ssLampGreen;
                rdNext[3] = ssLampRed;
                rdNext[4] = selChangedReg;
                rdNext[5] = haltReg;
                rdNext[6] = ampRecValidReg;
                rdNext[`SSL_LMP_AMPREC_LSB+4:`SSL_LMP_AMPREC_LSB] = ampRecReg;
                rdNext[`SSL_LMP_AMPNOW_LSB+4:`SSL_LMP_AMPNOW_LSB] = ampCount;
            end
            `SSL_ADDR_IRQ_STATUS:
                rdNext[`SSL_IRQ_WIDTH-1:0] = irqStatusReg;
            `SSL_ADDR_IRQ_MASK:
                rdNext[`SSL_IRQ_WIDTH-1:0] = irqMaskReg;
            default:
                rdNext = 32'h0000_0000;
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always @(posedge core_clk)
    begin
        if (reset)
            regRdata <= 32'h0000_0000;
        else if (regRead)
            regRdata <= rdNext;
        else
            regRdata <= 32'h0000_0000;
    end

endmodule // ssl_lamp_switch

// ### tb/ssl_lamp_monitor.sv
// Checker of lamp, capture and station range behaviour, bound to the block's ports.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps

module ssl_lamp_monitor (
    // Clock and reset
    input wire       core_clk,
    input wire       reset,
    // Inputs of the block
    input wire [3:0] rateSwitchPin,
    input wire [3:0] stationTensPin,
    input wire [3:0] stationOnesPin,
    input wire       linkActive,
    input wire       commError,
    input wire       dupStation,
    input wire [4:0] ampCount,
    // Lamps and settings
    input wire       runLampGreen,
    input wire       errLampRed,
    input wire       ssLampGreen,
    input wire       ssLampRed,
    input wire [2:0] linkRate,
    input wire       monitorMode,
    input wire [6:0] stationNumber,
    input wire       stationInRange,
    input wire       settingsValid,
    input wire       operationHalt
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_run_dark: assert property (!linkActive |=> !runLampGreen)
        else $error("run lamp lit with link down");
    a_run_lit: assert property (linkActive && settingsValid && $past(settingsValid)
        && !operationHalt && !dupStation |=> runLampGreen) else $error("run lamp dark online");
    a_halt_dark: assert property (operationHalt |=> !runLampGreen)
        else $error("run lamp lit while halted");
    a_halt_kept: assert property (operationHalt |=> operationHalt)
        else $error("halt released without reset");
    a_err_steady: assert property (settingsValid && $past(settingsValid)
        && (commError || !stationInRange || operationHalt) |=> errLampRed)
        else $error("error lamp not steady");
    a_dark_early: assert property (!settingsValid |=> !runLampGreen
        && !errLampRed && !ssLampGreen && !ssLampRed) else $error("lamp lit before capture");
    a_ss_colours: assert property (!(ssLampGreen && ssLampRed))
        else $error("sensor lamp both colours");
    a_ss_none: assert property (ampCount == 5'h00 |=> !ssLampGreen && !ssLampRed)
        else $error("sensor lamp lit with no amplifiers");
    a_mode_decode: assert property ($rose(settingsValid) && rateSwitchPin <= 4'h9
        |-> monitorMode == (rateSwitchPin >= 4'h5)
        && linkRate == rateSwitchPin[2:0] - ((rateSwitchPin >= 4'h5) ? 3'h5 : 3'h0))
        else $error("rate or mode decode wrong");
    a_station_form: assert property ($rose(settingsValid) && stationTensPin <= 4'h9
        && stationOnesPin <= 4'h9 |-> stationNumber == stationTensPin * 7'h0A + stationOnesPin)
        else $error("station number not decimal");
    a_range_bound: assert property (stationInRange |-> stationNumber >= 7'h01
        && stationNumber <= (monitorMode ? 7'h3E : 7'h3F)) else $error("station range wrong");
    a_settings_held: assert property (settingsValid && $past(settingsValid)
        |-> $stable(linkRate) && $stable(monitorMode) && $stable(stationNumber))
        else $error("settings changed after capture");
endmodule // ssl_lamp_monitor

bind ssl_lamp_switch ssl_lamp_monitor u_monitor (.core_clk, .reset, .rateSwitchPin,
    .stationTensPin, .stationOnesPin, .linkActive, .commError, .dupStation, .ampCount,
    .runLampGreen, .errLampRed, .ssLampGreen, .ssLampRed, .linkRate, .monitorMode,
    .stationNumber, .stationInRange, .settingsValid, .operationHalt);

// ### tb/ssl_master_model.sv
// Behavioural fieldbus master, seen through the protocol engine's link flags.
// Assumes the bench sets the master's rate and asks for faults by level.
`timescale 1ns/1ps

module ssl_master_model (
    // Clock and reset
    input  wire       core_clk,
    input  wire       reset,
    // Bench control
    input  wire [2:0] masterRate,
    input  wire       wantOnline,
    input  wire       wantErr,
    input  wire       wantDup,
    // Unit side
    input  wire [2:0] linkRate,
    output reg        linkActive,
    output reg        commError,
    output reg        dupStation
);
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            linkActive <= 1'b0;
            commError  <= 1'b0;
            dupStation <= 1'b0;
        end
        else
        begin
            // A master at another rate never reaches the unit, so the link stays down
            linkActive <= wantOnline && (masterRate == linkRate);
            commError  <= wantErr;
            dupStation <= wantDup;
        end
    end
endmodule // ssl_master_model

// ### tb/tb_status_lamp_and_switch_config.sv
// Self-checking bench: ten power-ups, one per rate/mode code, each with link,
// error, sensor count, interrupt and duplicate station cases.
// Assumes the master model stands in for the protocol engine.
`timescale 1ns/1ps
`include "ssl_consts.vh"

module tb_status_lamp_and_switch_config;
    reg         core_clk       = 1'b0;
    reg         reset          = 1'b1;
    reg  [3:0]  rateSwitchPin  = 4'h0;
    reg  [3:0]  stationTensPin = 4'h0;
    reg  [3:0]  stationOnesPin = 4'h0;
    reg  [4:0]  ampCount       = 5'h00;
    reg         ampCountValid  = 1'b0;
    reg  [7:0]  regAddr        = 8'h00;
    reg  [31:0] regWdata       = 32'h0000_0000;
    reg         regWrite       = 1'b0;
    reg         regRead        = 1'b0;
    reg  [2:0]  masterRate     = 3'h0;
    reg         wantOnline     = 1'b0;
    reg         wantErr        = 1'b0;
    reg         wantDup        = 1'b0;
    wire [31:0] regRdata;
    wire [2:0]  linkRate;
    wire [6:0]  stationNumber;
    wire        runLampGreen, errLampRed, ssLampGreen, ssLampRed, irq;
    wire        monitorMode, stationInRange, settingsValid, operationHalt;
    wire        linkActive, commError, dupStation;
    integer     failures = 0;
    integer     n_checks = 0;
    integer     seed     = 32'h14E8;
    integer     i, k, ones, zeros;
    reg  [3:0]  tens, unit;
    reg  [6:0]  station;
    reg         inRange;

    always #4 core_clk = ~core_clk;

    ssl_lamp_switch #(.FLASH_HALF_CYCLES(32'h0000_0004)) dut (.core_clk, .reset, .rateSwitchPin,
        .stationTensPin, .stationOnesPin, .linkActive, .commError, .dupStation, .ampCount,
        .ampCountValid, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .runLampGreen,
        .errLampRed, .ssLampGreen, .ssLampRed, .linkRate, .monitorMode, .stationNumber,
        .stationInRange, .settingsValid, .operationHalt, .irq);
    ssl_master_model u_master (.core_clk, .reset, .masterRate, .wantOnline, .wantErr,
        .wantDup, .linkRate, .linkActive, .commError, .dupStation);

    // ------------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------------
    task end_of_test;
    begin
        if (failures == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask

    task chkWord(input [31:0] got, input [31:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task chkBit(input got, input exp);
    begin
        chkWord({31'h0, got}, {31'h0, exp});
    end
    endtask

    task tick(input integer n);
    begin
        repeat (n) @(posedge core_clk);
    end
    endtask

    task wr(input [7:0] a, input [31:0] d);
    begin
        @(posedge core_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    end
    endtask

    // Read data stand only in the cycle after the strobe, so look there
    task rd(input [7:0] a, input [31:0] m, input [31:0] exp);
    begin
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 chkWord(regRdata & m, exp);
    end
    endtask

    task waitValid;
    begin
        k = 0;
        while (settingsValid !== 1'b1 && k < 300)
        begin
            tick(1);
            k = k + 1;
        end
        if (k == 300)
        begin
            failures = failures + 1;
            end_of_test;
        end
    end
    endtask

    function [2:0] expRate(input [3:0] c);
        expRate = c[2:0] - ((c >= 4'h5) ? 3'h5 : 3'h0);
    endfunction

    function expIn(input [3:0] c, input [6:0] n);
        expIn = (n >= 7'h01) && (n <= ((c >= 4'h5) ? 7'h3E : 7'h3F));
    endfunction

    function [31:0] cfgWord(input [3:0] c, input [6:0] n, input r);
        cfgWord = {18'h0_0000, 1'b1, r, c >= 4'h5, expRate(c), 1'b0, n};
    endfunction

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial
    begin
        for (i = 0; i < 10; i = i + 1)
        begin
            tens = 4'({$random(seed)} % 10);
            unit = 4'({$random(seed)} % 10);
            // Mode-edge station numbers mixed in with the random ones
            case (i)
                0: {tens, unit} = 8'h00;
                2: {tens, unit} = 8'h64;
                3: {tens, unit} = 8'h63;
                5: {tens, unit} = 8'h62;
                9: {tens, unit} = 8'h63;
                default: ;
            endcase
            station = tens * 7'h0A + unit;
            inRange = expIn(i[3:0], station);
            reset          <= 1'b1;
            wantOnline     <= 1'b0;
            wantErr        <= 1'b0;
            ampCountValid  <= 1'b0;
            ampCount       <= 5'(1 + {$random(seed)} % 15);
            rateSwitchPin  <= i[3:0];
            stationTensPin <= tens;
            stationOnesPin <= unit;
            masterRate     <= expRate(i[3:0]) + 3'h1;
            tick(4);
            reset <= 1'b0;
            waitValid;
            rd(`SSL_ADDR_CONFIG, 32'hFFFF_FFFF, cfgWord(i[3:0], station, inRange));
            tick(1);
            #1 chkWord(regRdata, 32'h0000_0000);
            rd(`SSL_ADDR_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
            rd(8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
            wantOnline <= 1'b1;
            tick(6);
            #1 chkBit(runLampGreen, 1'b0);
            chkBit(ssLampGreen | ssLampRed, 1'b0);
            masterRate <= expRate(i[3:0]);
            tick(4);
            #1 chkBit(runLampGreen, 1'b1);
            chkBit(errLampRed, ~inRange);
            ampCountValid <= 1'b1;
            tick(4);
            #1 chkBit(ssLampGreen, 1'b1);
            ampCount <= ampCount + 5'h01;
            tick(3);
            #1 chkBit(ssLampRed, 1'b1);
            chkBit(ssLampGreen, 1'b0);
            ampCount <= 5'h00;
            tick(3);
            #1 chkBit(ssLampGreen | ssLampRed, 1'b0);
            wantErr <= 1'b1;
            tick(4);
            #1 chkBit(errLampRed, 1'b1);
            rd(`SSL_ADDR_IRQ_STATUS, 32'h0000_0002, 32'h0000_0002);
            chkBit(irq, 1'b0);
            wr(`SSL_ADDR_IRQ_MASK, 32'h0000_0002);
            wantErr <= 1'b0;
            tick(3);
            #1 chkBit(irq, 1'b1);
            wr(`SSL_ADDR_IRQ_STATUS, 32'h0000_0002);
            tick(3);
            #1 chkBit(irq, 1'b0);
            stationOnesPin <= unit ^ 4'h1;
            rateSwitchPin  <= ~i[3:0];
            tick(6);
            ones  = 0;
            zeros = 0;
            for (k = 0; k < 16; k = k + 1)
            begin
                tick(1);
                #1 ones = ones + (errLampRed === 1'b1);
                zeros = zeros + (errLampRed === 1'b0);
            end
            if (inRange) chkBit(ones > 0 && zeros > 0, 1'b1);
            rd(`SSL_ADDR_CONFIG, 32'hFFFF_FFFF, cfgWord(i[3:0], station, inRange));
            wantErr <= 1'b1;
            tick(3);
            ones = 0;
            for (k = 0; k < 12; k = k + 1)
            begin
                tick(1);
                #1 ones = ones + (errLampRed === 1'b1);
            end
            chkWord(ones, 32'h0000_000C);
            // Pins go back first, or the change latch would set again at once
            wantErr        <= 1'b0;
            stationOnesPin <= unit;
            rateSwitchPin  <= i[3:0];
            tick(4);
            wr(`SSL_ADDR_CONTROL, 32'h0000_0001);
            tick(3);
            #1 chkBit(errLampRed, ~inRange);
            wantDup <= 1'b1;
            tick(1);
            wantDup <= 1'b0;
            tick(3);
            #1 chkBit(operationHalt, 1'b1);
            chkBit(runLampGreen, 1'b0);
            chkBit(errLampRed, 1'b1);
            rd(`SSL_ADDR_IRQ_STATUS, 32'hFFFF_FFFF, 32'h0000_001E);
            rd(`SSL_ADDR_LAMPS, 32'h0000_007F, 32'h0000_0062);
        end
        end_of_test;
    end
endmodule // tb_status_lamp_and_switch_config
